// [src/hdcs_pkg.sv]
// shared constants and types for the headphone dc servo control block
package hdcs_pkg;

    // register addresses on the plain register port
    localparam logic [7:0] ADDR_CTRL     = 8'h54;
    localparam logic [7:0] ADDR_TIMER    = 8'h55;
    localparam logic [7:0] ADDR_READBACK = 8'h58;
    localparam logic [7:0] ADDR_OFFSET   = 8'h59;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h5A;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h5B;

    // widths
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned NCHAN   = 2;
    localparam int unsigned OFS_W   = 8;
    localparam int unsigned TIMER_W = 4;
    localparam int unsigned CNT_W   = 25;

    // field positions, lowest bit of each two-bit per-channel field
    localparam int unsigned ENA_POS       = 0;
    localparam int unsigned LOAD_TRIG_POS = 2;
    localparam int unsigned MEAS_TRIG_POS = 4;
    localparam int unsigned MEAS_DONE_POS = 0;
    localparam int unsigned LOAD_DONE_POS = 4;
    localparam int unsigned CAL_DONE_POS  = 8;

    // reset values
    localparam logic [TIMER_W-1:0] TIMER_RST  = 4'hA;
    localparam logic [DATA_W-1:0]  OFFSET_RST = 16'h0000;
    localparam logic [OFS_W-1:0]   CORR_RST   = 8'h00;

    // correction durations in their own units, then in clock cycles
    localparam int unsigned CLK_FREQ_KHZ = 250000;
    localparam int unsigned MEAS_TIME_MS = 86;
    localparam int unsigned LOAD_TIME_MS = 2;
    localparam int unsigned MEAS_CYCLES  = MEAS_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned LOAD_CYCLES  = LOAD_TIME_MS * CLK_FREQ_KHZ;

    // per-channel correction sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MEAS = 3'b010,
        ST_LOAD = 3'b100
    } hdcs_state_t;

endpackage : hdcs_pkg

// [src/hdcs_chan.sv]
// one headphone channel's offset correction sequencer
`timescale 1ns/1ps
module hdcs_chan
    import hdcs_pkg::*;
#(
    parameter int unsigned MEAS_LEN = MEAS_CYCLES,
    parameter int unsigned LOAD_LEN = LOAD_CYCLES
) (
    // clock, reset, freeze
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             ce,
    // commands
    input  wire logic             enable,
    input  wire logic             measTrig,
    input  wire logic             loadTrig,
    // correction sources
    input  wire logic [OFS_W-1:0] measCode,
    input  wire logic [OFS_W-1:0] loadCode,
    // status and applied correction
    output logic                  measBusy,
    output logic                  loadBusy,
    output logic                  measDone,
    output logic                  loadDone,
    output logic [OFS_W-1:0]      applied
);

    hdcs_state_t      state_r,    state_nxt;
    logic [CNT_W-1:0] cnt_r,      cnt_nxt;
    logic [OFS_W-1:0] applied_r,  applied_nxt;
    logic             measDone_r, measDone_nxt;
    logic             loadDone_r, loadDone_nxt;

    ////////////////////////////////////////////////////////////////////////
    // next state: measurement wins when both triggers arrive together
    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        applied_nxt  = applied_r;
        measDone_nxt = measDone_r;
        loadDone_nxt = loadDone_r;
        unique case (state_r)
            ST_IDLE: begin
                if (enable && measTrig) begin
                    state_nxt    = ST_MEAS;
                    cnt_nxt      = CNT_W'(MEAS_LEN - 1);
                    measDone_nxt = 1'b0;
                    loadDone_nxt = 1'b0;
                end else if (enable && loadTrig) begin
                    state_nxt    = ST_LOAD;
                    cnt_nxt      = CNT_W'(LOAD_LEN - 1);
                    measDone_nxt = 1'b0;
                    loadDone_nxt = 1'b0;
                end
            end
            ST_MEAS: begin
                // disabling the channel abandons the run, leaving done low
                if (!enable) begin
                    state_nxt = ST_IDLE;
                end else if (cnt_r == '0) begin
                    state_nxt    = ST_IDLE;
                    applied_nxt  = measCode;
                    measDone_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_LOAD: begin
                if (!enable) begin
                    state_nxt = ST_IDLE;
                end else if (cnt_r == '0) begin
                    state_nxt    = ST_IDLE;
                    applied_nxt  = loadCode;
                    loadDone_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // registers, frozen while ce is low
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r    <= ST_IDLE;
            cnt_r      <= '0;
            applied_r  <= CORR_RST;
            measDone_r <= 1'b0;
            loadDone_r <= 1'b0;
        end else if (ce) begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            applied_r  <= applied_nxt;
            measDone_r <= measDone_nxt;
            loadDone_r <= loadDone_nxt;
        end
    end

    // busy flags decode straight from the one-hot state
    assign measBusy = (state_r == ST_MEAS);
    assign loadBusy = (state_r == ST_LOAD);
    assign measDone = measDone_r;
    assign loadDone = loadDone_r;
    assign applied  = applied_r;

endmodule : hdcs_chan

// [src/hdcs_servo_ctrl.sv]
// headphone dc offset servo control: registers, channels, interrupt
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module hdcs_servo_ctrl
    import hdcs_pkg::*;
#(
    parameter int unsigned MEAS_LEN = MEAS_CYCLES,
    parameter int unsigned LOAD_LEN = LOAD_CYCLES
) (
    // clock, reset, freeze
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              ce,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    // measurement results from the analogue servo loop
    input  wire logic [OFS_W-1:0]  leftMeasCode,
    input  wire logic [OFS_W-1:0]  rightMeasCode,
    // corrections applied to the headphone outputs
    output logic      [OFS_W-1:0]  leftCorrection,
    output logic      [OFS_W-1:0]  rightCorrection,
    output logic      [NCHAN-1:0]  servoEnable,
    // status to pins and interrupt controller
    output logic      [NCHAN-1:0]  calibrationDone,
    output logic                   irq
);

    // software state
    logic [NCHAN-1:0]   ena_r,      ena_nxt;
    logic [TIMER_W-1:0] timer_r,    timer_nxt;
    logic [DATA_W-1:0]  stored_r,   stored_nxt;
    logic [NCHAN-1:0]   status_r,   status_nxt;
    logic [NCHAN-1:0]   mask_r,     mask_nxt;
    logic [DATA_W-1:0]  rdata_r,    rdata_nxt;
    logic               irq_r,      irq_nxt;
    logic [NCHAN-1:0]   calPrev_r,  calPrev_nxt;
    logic [NCHAN-1:0]   calOut_r,   calOut_nxt;

    // channel wiring
    logic [NCHAN-1:0]   measTrig;
    logic [NCHAN-1:0]   loadTrig;
    logic [NCHAN-1:0]   measBusy;
    logic [NCHAN-1:0]   loadBusy;
    logic [NCHAN-1:0]   measDone;
    logic [NCHAN-1:0]   loadDone;
    logic [NCHAN-1:0]   calDone;
    logic [NCHAN-1:0]   calEvent;
    logic [OFS_W-1:0]   measIn  [NCHAN];
    logic [OFS_W-1:0]   applied [NCHAN];
    logic               wrCtrl;
    logic               wrStat;

    ////////////////////////////////////////////////////////////////////////
    // write decode; a frozen cycle takes no command
    assign wrCtrl = ce && regWr && (regAddr == ADDR_CTRL);
    assign wrStat = ce && regWr && (regAddr == ADDR_IRQ_STAT);

    assign measIn[0] = leftMeasCode;
    assign measIn[1] = rightMeasCode;

    ////////////////////////////////////////////////////////////////////////
    // one sequencer per headphone channel
    generate
        for (genvar i = 0; i < NCHAN; i++) begin : g_chan
            // triggers are write pulses only, never stored
            assign measTrig[i] = wrCtrl && regWdata[MEAS_TRIG_POS+i];
            assign loadTrig[i] = wrCtrl && regWdata[LOAD_TRIG_POS+i];
            assign calDone[i]  = measDone[i] | loadDone[i];

            hdcs_chan #(
                .MEAS_LEN (MEAS_LEN),
                .LOAD_LEN (LOAD_LEN)
            ) u_chan (
                .mclk     (mclk),
                .resetn   (resetn),
                .ce       (ce),
                .enable   (ena_nxt[i]),
                .measTrig (measTrig[i]),
                .loadTrig (loadTrig[i]),
                .measCode (measIn[i]),
                .loadCode (stored_r[i*OFS_W +: OFS_W]),
                .measBusy (measBusy[i]),
                .loadBusy (loadBusy[i]),
                .measDone (measDone[i]),
                .loadDone (loadDone[i]),
                .applied  (applied[i])
            );
        end
    endgenerate

    assign leftCorrection  = applied[0];
    assign rightCorrection = applied[1];

    // rising calibration-done is the interrupt event
    assign calEvent = calDone & ~calPrev_r;

    ////////////////////////////////////////////////////////////////////////
    // register file next values
    always_comb begin
        ena_nxt     = ena_r;
        timer_nxt   = timer_r;
        stored_nxt  = stored_r;
        mask_nxt    = mask_r;
        calPrev_nxt = calDone;
        calOut_nxt  = calDone;
        if (ce && regWr) begin
            unique case (regAddr)
                ADDR_CTRL:     ena_nxt    = regWdata[ENA_POS +: NCHAN];
                ADDR_TIMER:    timer_nxt  = regWdata[TIMER_W-1:0];
                ADDR_OFFSET:   stored_nxt = regWdata;
                ADDR_IRQ_MASK: mask_nxt   = regWdata[NCHAN-1:0];
                default:       ena_nxt    = ena_r;
            endcase
        end
    end

    // sticky status: a new event wins over a write-one-to-clear
    always_comb begin
        status_nxt = status_r;
        if (wrStat) begin
            status_nxt = status_nxt & ~regWdata[NCHAN-1:0];
        end
        status_nxt = status_nxt | calEvent;
        irq_nxt    = |(status_nxt & mask_nxt);
    end

    // read data stands only in the cycle after the strobe
    always_comb begin
        rdata_nxt = '0;
        if (ce && regRd) begin
            unique case (regAddr)
                ADDR_CTRL: begin
                    rdata_nxt[ENA_POS +: NCHAN]       = ena_r;
                    rdata_nxt[LOAD_TRIG_POS +: NCHAN] = loadBusy;
                    rdata_nxt[MEAS_TRIG_POS +: NCHAN] = measBusy;
                end
                ADDR_TIMER: begin
                    rdata_nxt[TIMER_W-1:0] = timer_r;
                end
                ADDR_READBACK: begin
                    rdata_nxt[MEAS_DONE_POS +: NCHAN] = measDone;
                    rdata_nxt[LOAD_DONE_POS +: NCHAN] = loadDone;
                    rdata_nxt[CAL_DONE_POS +: NCHAN]  = calDone;
                end
                ADDR_OFFSET: begin
                    // applied value, not the one last written
                    rdata_nxt = {applied[1], applied[0]};
                end
                ADDR_IRQ_STAT: begin
                    rdata_nxt[NCHAN-1:0] = status_r;
                end
                ADDR_IRQ_MASK: begin
                    rdata_nxt[NCHAN-1:0] = mask_r;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; rdata clears each active cycle so reads never linger
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ena_r     <= '0;
            timer_r   <= TIMER_RST;
            stored_r  <= OFFSET_RST;
            status_r  <= '0;
            mask_r    <= '0;
            rdata_r   <= '0;
            irq_r     <= 1'b0;
            calPrev_r <= '0;
            calOut_r  <= '0;
        end else if (ce) begin
            ena_r     <= ena_nxt;
            timer_r   <= timer_nxt;
            stored_r  <= stored_nxt;
            status_r  <= status_nxt;
            mask_r    <= mask_nxt;
            rdata_r   <= rdata_nxt;
            irq_r     <= irq_nxt;
            calPrev_r <= calPrev_nxt;
            calOut_r  <= calOut_nxt;
        end
    end

    assign regRdata        = rdata_r;
    assign irq             = irq_r;
    assign servoEnable     = ena_r;
    assign calibrationDone = calOut_r;

    ////////////////////////////////////////////////////////////////////////
    // checks on the block's own behaviour

    property p_ena_follows_write;
        @(posedge mclk) disable iff (!resetn)
        wrCtrl |=> (servoEnable == $past(regWdata[ENA_POS +: NCHAN]));
    endproperty
    a_ena_follows_write: assert property (p_ena_follows_write)
        else $error("servo enable did not follow control write");

    property p_meas_starts;
        @(posedge mclk) disable iff (!resetn)
        (measTrig[0] && ena_nxt[0] && !measBusy[0] && !loadBusy[0])
            |=> (measBusy[0] && !calDone[0]);
    endproperty
    a_meas_starts: assert property (p_meas_starts)
        else $error("left measurement did not start with done cleared");

    property p_load_applies;
        @(posedge mclk) disable iff (!resetn)
        $fell(loadBusy[1]) && $past(ena_nxt[1]) |->
            (loadDone[1] && rightCorrection == $past(stored_r[2*OFS_W-1:OFS_W]));
    endproperty
    a_load_applies: assert property (p_load_applies)
        else $error("right load did not apply stored value");

    property p_busy_readback;
        @(posedge mclk) disable iff (!resetn)
        (ce && regRd && regAddr == ADDR_CTRL) |=>
            (regRdata[MEAS_TRIG_POS +: NCHAN] == $past(measBusy)
             && regRdata[LOAD_TRIG_POS +: NCHAN] == $past(loadBusy));
    endproperty
    a_busy_readback: assert property (p_busy_readback)
        else $error("trigger readback does not show busy");

    property p_done_readback;
        @(posedge mclk) disable iff (!resetn)
        (ce && regRd && regAddr == ADDR_READBACK) |=>
            (regRdata[MEAS_DONE_POS +: NCHAN] == $past(measDone)
             && regRdata[LOAD_DONE_POS +: NCHAN] == $past(loadDone));
    endproperty
    a_done_readback: assert property (p_done_readback)
        else $error("completion readback wrong");

    property p_cal_or;
        @(posedge mclk) disable iff (!resetn)
        (ce && regRd && regAddr == ADDR_READBACK) |=>
            regRdata[CAL_DONE_POS +: NCHAN]
                == ($past(measDone) | $past(loadDone));
    endproperty
    a_cal_or: assert property (p_cal_or)
        else $error("calibration done is not the OR of both");

    property p_offset_read;
        @(posedge mclk) disable iff (!resetn)
        (ce && regRd && regAddr == ADDR_OFFSET) |=>
            regRdata == {$past(rightCorrection), $past(leftCorrection)};
    endproperty
    a_offset_read: assert property (p_offset_read)
        else $error("offset read does not show applied correction");

    property p_irq_event;
        @(posedge mclk) disable iff (!resetn)
        (ce && calEvent[0] && mask_nxt[0]) |=> irq ##1 (irq || $past(regWr));
    endproperty
    a_irq_event: assert property (p_irq_event)
        else $error("masked-in calibration event did not raise irq");

    property p_done_holds;
        @(posedge mclk) disable iff (!resetn)
        (measDone[0] && !measTrig[0] && !loadTrig[0]) |=> measDone[0];
    endproperty
    a_done_holds: assert property (p_done_holds)
        else $error("left done dropped without a new trigger");

    property p_gpio_status;
        @(posedge mclk) disable iff (!resetn)
        ce |=> (calibrationDone == $past(calDone));
    endproperty
    a_gpio_status: assert property (p_gpio_status)
        else $error("calibration done output lags wrongly");

    property p_meas_applies;
        @(posedge mclk) disable iff (!resetn)
        $fell(measBusy[0]) && $past(ena_nxt[0]) |->
            (measDone[0] && leftCorrection == $past(leftMeasCode));
    endproperty
    a_meas_applies: assert property (p_meas_applies)
        else $error("left measurement did not apply measured code");

    // a load trigger landing mid-measurement must not switch mode
    property p_busy_ignores_trig;
        @(posedge mclk) disable iff (!resetn)
        (ce && measBusy[0] && loadTrig[0] && ena_nxt[0]) |=> !loadBusy[0];
    endproperty
    a_busy_ignores_trig: assert property (p_busy_ignores_trig)
        else $error("left load started during a measurement");

    property p_no_start_disabled;
        @(posedge mclk) disable iff (!resetn)
        (ce && measTrig[0] && !ena_nxt[0] && !measBusy[0] && !loadBusy[0])
            |=> !measBusy[0];
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled)
        else $error("left measurement started while disabled");

    // an abort must leave the previously applied correction in place
    property p_abort_keeps;
        @(posedge mclk) disable iff (!resetn)
        (ce && (measBusy[0] || loadBusy[0]) && !ena_nxt[0]) |=>
            (!measBusy[0] && !loadBusy[0] && !calDone[0] && $stable(leftCorrection));
    endproperty
    a_abort_keeps: assert property (p_abort_keeps)
        else $error("left abort changed correction or reported done");

    // the event must win even against a clear in the same cycle
    property p_status_set_wins;
        @(posedge mclk) disable iff (!resetn)
        (ce && calEvent[1]) |=> status_r[1];
    endproperty
    a_status_set_wins: assert property (p_status_set_wins)
        else $error("right calibration event did not set status");

    // small-length builds only: default lengths exceed the delay bound
    generate
        if (LOAD_LEN <= 500) begin : g_len_chk
            property p_load_finishes;
                @(posedge mclk) disable iff (!resetn)
                (ce && loadBusy[1] && ena_r[1] && !wrCtrl && !$past(loadBusy[1]))
                    |-> ##[1:1000] (!loadBusy[1] || !ena_r[1]);
            endproperty
            a_load_finishes: assert property (p_load_finishes)
                else $error("right load ran too long");
        end
    endgenerate

endmodule : hdcs_servo_ctrl

// [sim/tb_top.sv]
// self-checking bench for the headphone dc servo control block
`timescale 1ns/1ps
module tb_top
    import hdcs_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////////
    // short run lengths keep the whole run to a few hundred cycles
    localparam int ML = 20;
    localparam int LL = 6;

    typedef struct {
        logic              w;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] e;
    } hdcs_tb_row_t;

    logic              mclk;
    logic              resetn;
    logic              ce;
    logic              regWr;
    logic              regRd;
    logic              irq;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata;
    logic [DATA_W-1:0] regRdata;
    logic [DATA_W-1:0] rdVal;
    logic [OFS_W-1:0]  leftMeasCode;
    logic [OFS_W-1:0]  rightMeasCode;
    logic [OFS_W-1:0]  leftCorrection;
    logic [OFS_W-1:0]  rightCorrection;
    logic [NCHAN-1:0]  servoEnable;
    logic [NCHAN-1:0]  calibrationDone;
    int                fails = 0;
    int                numChecks = 0;
    int                cyc = 0;
    int                tTrig = 0;
    int                t0 = 0;

    // reset values, then writes each read back: timer, offset (reads the applied value), read-only and unmapped places, control
    hdcs_tb_row_t rows [11] = '{
        '{1'b0, ADDR_TIMER,    16'h0000, 16'h000a},
        '{1'b0, ADDR_CTRL,     16'h0000, 16'h0000},
        '{1'b0, ADDR_READBACK, 16'h0000, 16'h0000},
        '{1'b0, ADDR_OFFSET,   16'h0000, 16'h0000},
        '{1'b0, ADDR_IRQ_STAT, 16'h0000, 16'h0000},
        '{1'b0, ADDR_IRQ_MASK, 16'h0000, 16'h0000},
        '{1'b1, ADDR_TIMER,    16'h0000, 16'h0000},
        '{1'b1, ADDR_OFFSET,   16'h807f, 16'h0000},
        '{1'b1, ADDR_READBACK, 16'hffff, 16'h0000},
        '{1'b1, 8'h60,         16'hffff, 16'h0000},
        '{1'b1, ADDR_CTRL,     16'h0003, 16'h0003}};

    ////////////////////////////////////////////////////////////////////////////////
    hdcs_servo_ctrl #(.MEAS_LEN(ML), .LOAD_LEN(LL)) u_dut (
        .mclk(mclk), .resetn(resetn), .ce(ce),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata),
        .leftMeasCode(leftMeasCode), .rightMeasCode(rightMeasCode),
        .leftCorrection(leftCorrection), .rightCorrection(rightCorrection),
        .servoEnable(servoEnable), .calibrationDone(calibrationDone), .irq(irq));

    // clock and a cycle counter used to time the corrections
    always #2 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkLen(input int got, input int exp);
        numChecks++;
        if (got != exp) begin
            fails++;
            $display("Error at %0t: run took %0d cycles, expected %0d", $time, got, exp);
        end
    endtask : chkLen

    // leading edge wait leaves a gap so a strobe is never set twice in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
        #1 tTrig = cyc;
    endtask : wr

    // read data stand only in the cycle after the strobe, zero after that
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rdVal = regRdata;
        @(posedge mclk);
        #1 chk(regRdata, 16'h0000);
    endtask : rd

    // bounded wait for the applied correction, then check the run length
    task automatic waitCorr(input bit rgt, input logic [7:0] exp, input int len, input int ts);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (n < 400 && (rgt ? rightCorrection : leftCorrection) !== exp);
        chkLen(cyc - ts, len);
    endtask : waitCorr

    task automatic finalReport();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finalReport

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        ce = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = '0;
        regWdata = '0;
        leftMeasCode = 8'hc3;
        rightMeasCode = 8'h80;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(rdVal, rows[i].e);
        end
        chk({14'h0, servoEnable}, 16'h0003);
        // stored-value run on the left, interrupt unmasked
        wr(ADDR_IRQ_MASK, 16'h0003);
        wr(ADDR_CTRL, 16'h0007);
        t0 = tTrig;
        rd(ADDR_CTRL);
        chk(rdVal, 16'h0007);
        waitCorr(1'b0, 8'h7f, LL, t0);
        @(posedge mclk);
        #1 chk({14'h0, calibrationDone}, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        rd(ADDR_READBACK);
        chk(rdVal, 16'h0110);
        rd(ADDR_OFFSET);
        chk(rdVal, 16'h007f);
        rd(ADDR_CTRL);
        chk(rdVal, 16'h0003);
        rd(ADDR_IRQ_STAT);
        chk(rdVal, 16'h0001);
        wr(ADDR_IRQ_STAT, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        // measuring run on the left; a load trigger while busy must be ignored
        wr(ADDR_CTRL, 16'h0013);
        t0 = tTrig;
        rd(ADDR_READBACK);
        chk(rdVal, 16'h0000);
        wr(ADDR_CTRL, 16'h0007);
        waitCorr(1'b0, 8'hc3, ML, t0);
        rd(ADDR_READBACK);
        chk(rdVal, 16'h0101);
        rd(ADDR_OFFSET);
        chk(rdVal, 16'h00c3);
        wr(ADDR_IRQ_STAT, 16'h0003);
        // measuring run on the right with its interrupt masked out
        wr(ADDR_IRQ_MASK, 16'h0001);
        wr(ADDR_CTRL, 16'h0023);
        t0 = tTrig;
        rd(ADDR_CTRL);
        chk(rdVal, 16'h0023);
        waitCorr(1'b1, 8'h80, ML, t0);
        @(posedge mclk);
        #1 chk({14'h0, calibrationDone}, 16'h0003);
        chk({15'h0, irq}, 16'h0000);
        rd(ADDR_IRQ_STAT);
        chk(rdVal, 16'h0002);
        rd(ADDR_READBACK);
        chk(rdVal, 16'h0303);
        rd(ADDR_OFFSET);
        chk(rdVal, 16'h80c3);
        // stored-value run on the right from a fresh stored word
        wr(ADDR_OFFSET, 16'h5a7f);
        wr(ADDR_CTRL, 16'h000b);
        t0 = tTrig;
        waitCorr(1'b1, 8'h5a, LL, t0);
        rd(ADDR_READBACK);
        chk(rdVal, 16'h0321);
        rd(ADDR_OFFSET);
        chk(rdVal, 16'h5ac3);
        // dropping the enable mid-run aborts; the old correction must stay
        @(posedge mclk);
        leftMeasCode <= 8'h11;
        wr(ADDR_CTRL, 16'h0011);
        wr(ADDR_CTRL, 16'h0000);
        chk({14'h0, servoEnable}, 16'h0000);
        repeat (ML + 4) @(posedge mclk);
        #1 chk({8'h0, leftCorrection}, 16'h00c3);
        rd(ADDR_READBACK);
        chk(rdVal, 16'h0220);
        wr(ADDR_CTRL, 16'h0010);
        rd(ADDR_CTRL);
        chk(rdVal, 16'h0000);
        // strobes with the clock enable low are ignored
        @(posedge mclk);
        ce <= 1'b0;
        wr(ADDR_TIMER, 16'h000f);
        @(posedge mclk);
        ce <= 1'b1;
        rd(ADDR_TIMER);
        chk(rdVal, 16'h0000);
        // second reset in the middle of a run
        wr(ADDR_CTRL, 16'h0023);
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk({leftCorrection, rightCorrection}, 16'h0000);
        chk({14'h0, calibrationDone}, 16'h0000);
        rd(ADDR_TIMER);
        chk(rdVal, 16'h000a);
        rd(ADDR_CTRL);
        chk(rdVal, 16'h0000);
        finalReport();
    end

    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        finalReport();
    end
endmodule : tb_top
